//--- design/aerx_unit.sv
// Purpose: address error detection and exception return sequencing
// Assumes: stack reads answered by rdDone/rdBusErr one word at a time
// Notes:   halt cleared only by rst
// Contract
// (RQ1) odd word/long/fetch address raises address error
// (RQ2) abort cycle, begin exception processing at once
// (RQ3) same sequence as bus error, own vector
// (RQ4) address error during group-0 processing halts
// (RQ5) address error pushes long restartable frame
// (RQ6) retry uses stacked address; odd again faults
// (RQ7) upper byte flag on high peripheral-move transfer
// (RQ8) read SR, PC, format; short resumes
// (RQ9) unknown format code gives format error
// (RQ10) check version bits at SP+26 only
// (RQ11) stack pointer unchanged until frame read
// (RQ12) probe SP+56; bus error there takes bus error
// (RQ13) later bus error halts as double fault
// (RQ14) restored frame reloads state, resumes instruction
// (RQ15) no_retry_flag set skips rerun
// (RQ16) halt leaves only on external reset
// (RQ17) restartable fault pushes 22 extra words
// (RQ18) odd byte access never faults
`timescale 1ns/100ps
module aerx_unit (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    // access check
    input  wire logic                       accValid,
    input  wire logic [aerx_pkg::ADDR_W-1:0] accAddr,
    input  wire logic [1:0]                 accSize,
    input  wire logic                       accFetch,
    input  wire logic                       accBusErr,
    input  wire logic                       periphMoveOp,
    input  wire logic                       periphHighPart,
    input  wire logic                       inGroup0,
    // exception request out
    output logic                            accAbort,
    output logic                            excStart,
    output logic [7:0]                      excVector,
    output logic                            excLongFrame,
    output logic [4:0]                      excExtraWords,
    output logic                            upperByteFlag,
    output logic [aerx_pkg::ADDR_W-1:0]     faultAddr,
    output logic                            halted,
    // exception return
    input  wire logic                       exceptionReturnOp,
    input  wire logic [aerx_pkg::ADDR_W-1:0] spIn,
    output logic                            rdReq,
    output logic [aerx_pkg::ADDR_W-1:0]     rdAddr,
    input  wire logic                       rdDone,
    input  wire logic                       rdBusErr,
    input  wire logic [15:0]                rdData,
    output logic                            spLoad,
    output logic [aerx_pkg::ADDR_W-1:0]     spNew,
    output logic                            stateLoad,
    output logic [15:0]                     restoredSr,
    output logic [31:0]                     restoredPc,
    output logic                            retryReq,
    output logic [aerx_pkg::ADDR_W-1:0]     retryAddr,
    output logic                            rteBusy
);
    import aerx_pkg::*;

    aerx_state_t           state;
    logic [7:0]            ofs;
    logic [3:0]            fmt;
    logic [15:0]           ssw;
    logic [31:0]           fltWord;
    logic                  oddHit;
    logic                  retryOdd;
    logic [ADDR_W-1:0]     base;

    //----------------------------------------
    // access alignment check
    //----------------------------------------
    // byte operands never fault on odd addresses
    assign oddHit = accValid && accAddr[0]
                    && (accFetch || accSize != SZ_BYTE);    // [RQ1] [RQ18]
    assign retryOdd = (state == AERX_RERUN) && retryAddr[0];  // [RQ6]
    assign accAbort = oddHit;                               // [RQ2]
    assign rdReq   = (state == AERX_HEAD) || (state == AERX_VERSION)
                     || (state == AERX_PROBE) || (state == AERX_REST);
    assign rdAddr  = base + {{(ADDR_W-8){1'b0}}, ofs};
    assign rteBusy = state != AERX_IDLE && state != AERX_HALT;

    // fault reporting, one-cycle start pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            excStart      <= 1'b0;
            excVector     <= 8'h00;
            excLongFrame  <= 1'b0;
            excExtraWords <= 5'h00;
            upperByteFlag <= 1'b0;
            faultAddr     <= '0;
        end else begin
            excStart <= 1'b0;
            if (!halted && (oddHit || retryOdd) && !(inGroup0 && oddHit)) begin
                excStart      <= 1'b1;                      // [RQ2]
                excVector     <= VEC_ADDRERR;               // [RQ3]
                excLongFrame  <= 1'b1;                      // [RQ5]
                excExtraWords <= LONG_EXTRA;                // [RQ17]
                faultAddr     <= oddHit ? accAddr : retryAddr;
                upperByteFlag <= oddHit && periphMoveOp && periphHighPart; // [RQ7]
            end else if (!halted && accValid && accBusErr && !inGroup0) begin
                excStart      <= 1'b1;
                excVector     <= VEC_BUSERR;                // [RQ3]
                excLongFrame  <= 1'b1;
                excExtraWords <= LONG_EXTRA;                // [RQ17]
                faultAddr     <= accAddr;
                upperByteFlag <= periphMoveOp && periphHighPart; // [RQ7]
            end else if (state == AERX_HEAD && rdDone && !rdBusErr
                         && ofs == OFS_FMT && rdData[15:12] != FMT_SHORT
                         && rdData[15:12] != FMT_LONG) begin
                excStart      <= 1'b1;                      // [RQ9]
                excVector     <= VEC_FORMAT;
                excLongFrame  <= 1'b0;
                excExtraWords <= 5'h00;
            end else if (state == AERX_VERSION && rdDone && !rdBusErr
                         && rdData[VER_LSB+3:VER_LSB] != VERSION) begin
                excStart      <= 1'b1;                      // [RQ10]
                excVector     <= VEC_FORMAT;
                excLongFrame  <= 1'b0;
                excExtraWords <= 5'h00;
            end else if (rdDone && rdBusErr && (state == AERX_HEAD
                         || state == AERX_VERSION || state == AERX_PROBE)) begin
                excStart      <= 1'b1;                      // [RQ12]
                excVector     <= VEC_BUSERR;
                excLongFrame  <= 1'b1;
                excExtraWords <= LONG_EXTRA;
                faultAddr     <= rdAddr;
            end
        end
    end

    //----------------------------------------
    // halt on double fault
    //----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            halted <= 1'b0;                                 // [RQ16]
        end else if (inGroup0 && (oddHit || (accValid && accBusErr))) begin
            halted <= 1'b1;                                 // [RQ4]
        end else if (state == AERX_REST && rdDone && rdBusErr) begin
            halted <= 1'b1;                                 // [RQ13]
        end
    end

    //----------------------------------------
    // exception return sequencer
    //----------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state      <= AERX_IDLE;
            ofs        <= 8'h00;
            fmt        <= 4'h0;
            ssw        <= 16'h0000;
            fltWord    <= 32'h0;
            base       <= '0;
            restoredSr <= 16'h0000;
            restoredPc <= 32'h0;
            retryAddr  <= '0;
            spLoad     <= 1'b0;
            spNew      <= '0;
            stateLoad  <= 1'b0;
            retryReq   <= 1'b0;
        end else begin
            spLoad    <= 1'b0;
            stateLoad <= 1'b0;
            retryReq  <= 1'b0;
            case (state)
                AERX_IDLE: begin
                    if (exceptionReturnOp && !halted) begin
                        base  <= spIn;                      // [RQ11]
                        ofs   <= OFS_SR;
                        state <= AERX_HEAD;
                    end
                end
                AERX_HEAD: begin
                    if (rdDone && rdBusErr) begin
                        state <= AERX_IDLE;
                    end else if (rdDone) begin
                        case (ofs)
                            OFS_SR: restoredSr <= rdData;   // [RQ8]
                            OFS_PC: restoredPc[31:16] <= rdData;
                            OFS_FMT: fmt <= rdData[15:12];
                            default: restoredPc[15:0] <= rdData;
                        endcase
                        if (ofs == OFS_FMT) begin
                            if (rdData[15:12] == FMT_SHORT) begin
                                spNew     <= base + {{(ADDR_W-8){1'b0}}, SHORT_SIZE};
                                spLoad    <= 1'b1;          // [RQ8]
                                stateLoad <= 1'b1;
                                state     <= AERX_IDLE;
                            end else if (rdData[15:12] == FMT_LONG) begin
                                ofs   <= OFS_VERSION;
                                state <= AERX_VERSION;
                            end else begin
                                state <= AERX_IDLE;         // [RQ9]
                            end
                        end else begin
                            ofs <= ofs + WORD_STEP;
                        end
                    end
                end
                AERX_VERSION: begin
                    if (rdDone && rdBusErr) begin
                        state <= AERX_IDLE;
                    end else if (rdDone) begin
                        if (rdData[VER_LSB+3:VER_LSB] == VERSION) begin
                            ofs   <= OFS_LAST;              // [RQ12]
                            state <= AERX_PROBE;
                        end else begin
                            state <= AERX_IDLE;             // [RQ10]
                        end
                    end
                end
                AERX_PROBE: begin
                    if (rdDone && rdBusErr) begin
                        state <= AERX_IDLE;                 // [RQ12]
                    end else if (rdDone) begin
                        ofs   <= OFS_SSW;
                        state <= AERX_REST;
                    end
                end
                AERX_REST: begin
                    if (rdDone && rdBusErr) begin
                        state <= AERX_HALT;                 // [RQ13]
                    end else if (rdDone) begin
                        if (ofs == OFS_SSW) ssw <= rdData;
                        if (ofs == OFS_FAULT) fltWord[31:16] <= rdData;
                        if (ofs == OFS_FAULT + WORD_STEP) fltWord[15:0] <= rdData;
                        if (ofs == OFS_LAST - WORD_STEP) begin
                            spNew     <= base + {{(ADDR_W-8){1'b0}}, OFS_END};
                            spLoad    <= 1'b1;              // [RQ11]
                            stateLoad <= 1'b1;              // [RQ14]
                            retryAddr <= fltWord[ADDR_W-1:0];
                            state     <= ssw[SSW_NORETRY] ? AERX_IDLE : AERX_RERUN; // [RQ15]
                        end else begin
                            ofs <= ofs + WORD_STEP;
                        end
                    end
                end
                AERX_RERUN: begin
                    retryReq <= !retryAddr[0];              // [RQ6]
                    state    <= AERX_IDLE;
                end
                AERX_HALT: begin
                    state <= AERX_HALT;                     // [RQ16]
                end
                default: begin
                    state <= AERX_IDLE;
                end
            endcase
        end
    end

    //----------------------------------------
    // checks
    //----------------------------------------
    a_byte_no_fault: assert property (@(posedge ref_clk) disable iff (rst) // [RQ18]
        accValid && accSize == SZ_BYTE && !accFetch |-> !accAbort)
        else $error("byte access aborted");
    a_odd_word_abort: assert property (@(posedge ref_clk) disable iff (rst) // [RQ1]
        accValid && accAddr[0] && accSize == SZ_WORD |-> accAbort)
        else $error("odd word not aborted");
    a_addr_vector: assert property (@(posedge ref_clk) disable iff (rst) // [RQ3]
        oddHit && !inGroup0 && !halted |=> excStart && excVector == VEC_ADDRERR
        && excExtraWords == LONG_EXTRA)
        else $error("address error vector wrong");
    a_group0_halt: assert property (@(posedge ref_clk) disable iff (rst) // [RQ4]
        oddHit && inGroup0 |=> halted)
        else $error("no halt on nested fault");
    a_halt_sticky: assert property (@(posedge ref_clk) disable iff (rst) // [RQ16]
        halted |=> halted)
        else $error("halt left without reset");
    a_sp_hold: assert property (@(posedge ref_clk) disable iff (rst) // [RQ11]
        spLoad |-> $past(state) == AERX_REST || $past(state) == AERX_HEAD)
        else $error("stack pointer moved early");
    a_rest_fault: assert property (@(posedge ref_clk) disable iff (rst) // [RQ13]
        state == AERX_REST && rdDone && rdBusErr |=> halted && state == AERX_HALT)
        else $error("double fault not halted");
    a_bad_version: assert property (@(posedge ref_clk) disable iff (rst) // [RQ10]
        state == AERX_VERSION && rdDone && !rdBusErr
        && rdData[VER_LSB+3:VER_LSB] != VERSION |=> excVector == VEC_FORMAT
        && state == AERX_IDLE)
        else $error("version mismatch missed");
endmodule : aerx_unit

//--- design/aerx_pkg.sv
// Purpose: shared constants for the address error and exception return unit
// Assumes: 16-bit stack words, byte addresses, 24-bit address bus
// Notes:   version value is arbitrary
package aerx_pkg;
    localparam int ADDR_W = 24;
    // access sizes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    // exception kinds, not referenced by the unit
    localparam logic [1:0] EXC_NONE   = 2'h0;
    localparam logic [1:0] EXC_BUSERR = 2'h1;
    localparam logic [1:0] EXC_ADDRERR = 2'h2;
    localparam logic [1:0] EXC_FORMAT = 2'h3;
    // vector numbers
    localparam logic [7:0] VEC_BUSERR  = 8'h02;
    localparam logic [7:0] VEC_ADDRERR = 8'h03;
    localparam logic [7:0] VEC_FORMAT  = 8'h0e;
    // frame format codes
    localparam logic [3:0] FMT_SHORT = 4'h0;
    localparam logic [3:0] FMT_LONG  = 4'h8;
    // stack offsets in bytes
    localparam logic [7:0] OFS_SR      = 8'h00;
    localparam logic [7:0] OFS_PC      = 8'h02;
    localparam logic [7:0] OFS_FMT     = 8'h06;
    localparam logic [7:0] OFS_SSW     = 8'h08;
    localparam logic [7:0] OFS_FAULT   = 8'h0a;
    localparam logic [7:0] OFS_VERSION = 8'h1a;   // SP + 26
    localparam logic [7:0] OFS_LAST    = 8'h38;   // SP + 56
    localparam logic [7:0] OFS_END     = 8'h3a;   // frame size
    localparam logic [7:0] SHORT_SIZE  = 8'h08;
    localparam logic [7:0] WORD_STEP   = 8'h02;
    // status word and version word field positions
    localparam int SSW_NORETRY = 15;
    localparam int SSW_UPPER   = 10;
    localparam int VER_LSB     = 10;
    localparam logic [3:0] VERSION = 4'h5;        // arbitrary value
    localparam logic [4:0] LONG_EXTRA = 5'h16;    // 22 extra words pushed
    typedef enum logic [2:0] {
        AERX_IDLE    = 3'b000,
        AERX_HEAD    = 3'b001,
        AERX_VERSION = 3'b010,
        AERX_PROBE   = 3'b011,
        AERX_REST    = 3'b100,
        AERX_RERUN   = 3'b101,
        AERX_HALT    = 3'b110
    } aerx_state_t;
endpackage : aerx_pkg

//--- testbench/aerx_stack_mem.sv
// Purpose: supervisor stack memory answering exception return reads
// Assumes: frame base aligned to 64 bytes, one word per read
// Notes:   data goes to its inverse once a read is released
`timescale 1ns/100ps
module aerx_stack_mem (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // read port
    input  wire logic                        rdReq,
    input  wire logic [aerx_pkg::ADDR_W-1:0] rdAddr,
    output logic                             rdDone,
    output logic                             rdBusErr,
    output logic [15:0]                      rdData,
    // test control
    input  wire logic [1:0]                  lat,
    input  wire logic                        errEn,
    input  wire logic [5:0]                  errOfs
);
    logic [15:0] mem [0:31];
    logic [1:0]  cnt;
    // answer a held request after lat idle cycles
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            rdDone <= 1'b0;
            rdBusErr <= 1'b0;
            rdData <= 16'h0;
        end else begin
            rdDone <= 1'b0;
            rdBusErr <= 1'b0;
            if (rdReq && !rdDone) begin
                if (cnt >= lat) begin
                    rdDone <= 1'b1;
                    rdData <= mem[rdAddr[5:1]];
                    rdBusErr <= errEn && (rdAddr[5:0] == errOfs); // fault injection
                    cnt <= 2'h0;
                end else begin
                    cnt <= cnt + 2'h1;
                end
            end else if (rdDone) begin
                rdData <= ~rdData; // released: no stale value
            end
        end
    end
endmodule : aerx_stack_mem

//--- testbench/test_aerx_unit.sv
// Purpose: self-checking bench for the address error and return unit
// Assumes: format code in bits 15-12 of the format word
// Notes:   expectations come from a behavioural model in the tasks
`timescale 1ns/100ps
module test_aerx_unit;
    import aerx_pkg::*;
    logic ref_clk, rst, accValid, accFetch, accBusErr, pmOp, pmHi, inGroup0, rteOp;
    logic accAbort, excStart, excLongFrame, upperByteFlag, halted, rdReq, rdDone;
    logic rdBusErr, spLoad, stateLoad, retryReq, rteBusy, errEn;
    logic [23:0] accAddr, faultAddr, rdAddr, spNew, retryAddr, got[$];
    logic [23:0] sp = 24'h000400;
    logic [15:0] rdData, restoredSr;
    logic [31:0] restoredPc, seed = 32'd56;
    logic [7:0]  excVector;
    logic [4:0]  excExtraWords;
    logic [1:0]  accSize, lat;
    logic [5:0]  errOfs;
    int failures = 0, compares = 0, cyc = 0, nEx, nSp, nSt, nRt;
    aerx_unit u_dut (.ref_clk(ref_clk), .rst(rst), .accValid(accValid), .accAddr(accAddr),
        .accSize(accSize), .accFetch(accFetch), .accBusErr(accBusErr), .periphMoveOp(pmOp),
        .periphHighPart(pmHi), .inGroup0(inGroup0), .accAbort(accAbort), .excStart(excStart),
        .excVector(excVector), .excLongFrame(excLongFrame), .excExtraWords(excExtraWords),
        .upperByteFlag(upperByteFlag), .faultAddr(faultAddr), .halted(halted),
        .exceptionReturnOp(rteOp), .spIn(sp), .rdReq(rdReq), .rdAddr(rdAddr), .rdDone(rdDone),
        .rdBusErr(rdBusErr), .rdData(rdData), .spLoad(spLoad), .spNew(spNew),
        .stateLoad(stateLoad), .restoredSr(restoredSr), .restoredPc(restoredPc),
        .retryReq(retryReq), .retryAddr(retryAddr), .rteBusy(rteBusy));
    aerx_stack_mem u_mem (.ref_clk(ref_clk), .rst(rst), .rdReq(rdReq), .rdAddr(rdAddr),
        .rdDone(rdDone), .rdBusErr(rdBusErr), .rdData(rdData), .lat(lat), .errEn(errEn),
        .errOfs(errOfs));
    // -------------------------------------------------------------
    // clock, watchdog and event monitor
    // -------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (rdDone) got.push_back(rdAddr - sp);
        if (spLoad) nSp++;
        if (stateLoad) nSt++;
        if (retryReq) nRt++;
        if (excStart) nEx++;
        // watchdog last, so nothing runs after the closing report
        if (cyc >= 20000) begin
            failures++;
            end_of_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic clr();
        got.delete();
        nEx = 0; nSp = 0; nSt = 0; nRt = 0;
    endtask : clr
    task automatic do_reset();
        rst = 1'b1;
        repeat (10) step();
        rst = 1'b0;
        step();
    endtask : do_reset
    task automatic end_of_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_of_test
    // one presented access; be marks a bus error on a peripheral move byte
    task automatic acc(input logic [23:0] a, input logic [1:0] sz, input logic f, be, hi);
        logic ab;
        logic ex;
        clr();
        ab = a[0] & (f | (sz != SZ_BYTE));
        ex = (ab | be) & !inGroup0; // nested fault halts, no new exception
        accAddr = a; accSize = sz; accFetch = f; accBusErr = be; pmOp = be; pmHi = hi;
        accValid = 1'b1;
        #1 chk("accAbort", ab, accAbort);
        step();
        accValid = 1'b0;
        accBusErr = 1'b0;
        repeat (3) step();
        chk("excStart", ex, nEx);
        if (ex) begin
            chk("excVector", ab ? VEC_ADDRERR : VEC_BUSERR, excVector);
            chk("faultAddr", a, faultAddr);
            chk("excLongFrame", 1'b1, excLongFrame);
            chk("excExtraWords", LONG_EXTRA, excExtraWords);
        end
        if (ex) chk("upperByteFlag", be & hi, upperByteFlag);
    endtask : acc
    // one exception return against a prepared frame, with model of the outcome
    task automatic exception_return_op(input logic [15:0] fmt, ver, ssw, flo, input logic eEn,
                       input logic [5:0] eOfs);
        logic [15:0] w [0:31];
        logic [23:0] exp[$], eSp;
        logic [7:0]  eVec;
        logic        eHalt, eRt;
        int          o;
        for (o = 0; o < 32; o++) w[o] = 16'(rnd());
        w[3] = fmt; w[4] = ssw; w[6] = flo; w[13] = ver;
        for (o = 0; o < 32; o++) u_mem.mem[o] = w[o];
        lat = 2'(rnd()); errEn = eEn; errOfs = eOfs;
        eVec = 8'h0; eHalt = 1'b0; eRt = 1'b0; eSp = 24'h0;
        for (o = 0; o < 8 && eVec == 8'h0; o += 2) begin
            exp.push_back(24'(o));
            if (eEn && eOfs == o) eVec = VEC_BUSERR;
        end
        if (eVec != 8'h0) ;
        else if (fmt[15:12] == FMT_SHORT) eSp = sp + 24'h8;
        else if (fmt[15:12] != FMT_LONG) eVec = VEC_FORMAT;
        else begin
            exp.push_back(24'd26);
            if (ver[13:10] != VERSION) eVec = VEC_FORMAT;
            else begin
                exp.push_back(24'd56);
                if (eEn && eOfs == 56) eVec = VEC_BUSERR;
                else begin
                    for (o = 8; o < 56 && !eHalt; o += 2) begin
                        exp.push_back(24'(o));
                        eHalt = eEn && eOfs == o;
                    end
                    if (!eHalt) eSp = sp + 24'd58;
                    if (!eHalt && !ssw[SSW_NORETRY]) begin
                        if (flo[0]) eVec = VEC_ADDRERR;
                        else eRt = 1'b1;
                    end
                end
            end
        end
        clr();
        rteOp = 1'b1;
        step();
        rteOp = 1'b0;
        for (o = 0; o < 400 && rteBusy !== 1'b0; o++) step();
        repeat (4) step();
        chk("reads", exp.size(), got.size());
        for (o = 0; o < exp.size() && o < got.size(); o++)
            chk("rdAddr", exp[o], got[o]);
        chk("excStart", eVec != 8'h0, nEx);
        if (eVec != 8'h0) chk("excVector", eVec, excVector);
        chk("halted", eHalt, halted);
        chk("spLoad", eSp != 24'h0, nSp);
        chk("stateLoad", eSp != 24'h0, nSt);
        if (eSp != 24'h0) begin
            chk("spNew", eSp, spNew);
            chk("restoredSr", w[0], restoredSr);
            chk("restoredPc", {w[1], w[2]}, restoredPc);
        end
        chk("retryReq", eRt, nRt);
        if (eRt) chk("retryAddr", {w[5][7:0], flo}, retryAddr);
    endtask : exception_return_op
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        accValid = 0; accAddr = 0; accSize = 0; accFetch = 0; accBusErr = 0; pmOp = 0;
        pmHi = 0; inGroup0 = 0; rteOp = 0; lat = 0; errEn = 0; errOfs = 0;
        do_reset();
        for (int i = 0; i < 24; i++) begin
            acc(24'(rnd()), 2'(i % 3), i % 4 == 3, 1'b0, 1'b0);
        end
        acc(24'h000101, SZ_BYTE, 1'b0, 1'b1, 1'b1);
        acc(24'h000102, SZ_BYTE, 1'b0, 1'b1, 1'b0);
        exception_return_op(16'h0000, 16'h0, 16'h0, 16'h0, 1'b0, 6'd0);
        exception_return_op(16'h8000, 16'h0, 16'h0, 16'h0, 1'b1, 6'd2);
        exception_return_op(16'h3000, 16'h0, 16'h0, 16'h0, 1'b0, 6'd0);
        exception_return_op(16'h8000, {2'h0, VERSION + 4'h1, 10'h0}, 16'h0, 16'h0, 1'b0, 6'd0);
        exception_return_op(16'h8000, {2'h0, VERSION, 10'h0f3}, 16'h0, 16'h0, 1'b1, 6'd56);
        exception_return_op(16'h8000, {2'h0, VERSION, 10'h0f3}, 16'h0, 16'h1234, 1'b0, 6'd0);
        exception_return_op(16'h8000, {2'h0, VERSION, 10'h0f3}, 16'h8000, 16'h1234, 1'b0, 6'd0);
        exception_return_op(16'h8000, {2'h0, VERSION, 10'h0f3}, 16'h0, 16'h1235, 1'b0, 6'd0);
        exception_return_op(16'h8000, {2'h0, VERSION, 10'h0f3}, 16'h0, 16'h0, 1'b1, 6'd20);
        do_reset();
        chk("halted", 1'b0, halted);
        inGroup0 = 1'b1;
        acc(24'h000203, SZ_WORD, 1'b0, 1'b0, 1'b0);
        chk("halted", 1'b1, halted);
        rteOp = 1'b1;
        step();
        rteOp = 1'b0;
        chk("rteBusy", 1'b0, rteBusy);
        do_reset();
        chk("halted", 1'b0, halted);
        end_of_test();
    end
endmodule : test_aerx_unit
